// ### core/bus_mgmt_regs.svh
`ifndef BUS_MGMT_REGS_SVH
`define BUS_MGMT_REGS_SVH

// Register offsets on the host register port
`define OFS_GUID_ROM_PORT  8'h04
`define OFS_RETRY_LIMITS   8'h08
`define OFS_SWAP_DATA      8'h0C
`define OFS_SWAP_COMPARE   8'h10
`define OFS_SWAP_CONTROL   8'h14
`define OFS_ROM_HEADER     8'h18
`define OFS_BUS_ID         8'h1C
`define OFS_BUS_OPTIONS    8'h20
`define OFS_UID_HIGH       8'h24
`define OFS_UID_LOW        8'h28

// Retry limit fields
`define PHYS_RETRY_HI      15
`define PHYS_RETRY_LO      11
`define SWRSP_RETRY_HI     7
`define SWRSP_RETRY_LO     4
`define REQ_RETRY_HI       3
`define REQ_RETRY_LO       0

// Swap control fields
`define SWAP_DONE_BIT      31
`define SWAP_SEL_HI        1
`define SWAP_SEL_LO        0

// Resource reload values
`define BM_ID_RESET        32'h0000003F
`define BANDWIDTH_RESET    32'h00001333
`define CHANNELS_RESET     32'hFFFFFFFF

// Constant bus identification
`define BUS_ID_VALUE       32'h31333934

// Bus options fields and reset values
`define BUS_OPT_WR_MASK    32'hF8FFF0C0
`define MAX_REC_HI         15
`define MAX_REC_LO         12
`define MAX_REC_HW_RESET   4'h9
`define GEN_HI             7
`define GEN_LO             6
`define LINK_SPD_HI        2
`define LINK_SPD_LO        0
`define LINK_SPD_HW_RESET  3'h2

// GUID ROM port byte field
`define ROM_BYTE_HI        23
`define ROM_BYTE_LO        16

`endif

// ### core/bus_mgmt_pkg.sv
package bus_mgmt_pkg;

	// Acknowledge outcome seen by a transmit unit
	typedef enum logic [1:0] {
		ACK_COMPLETE,
		ACK_BUSY,
		ACK_DATA_ERROR,
		ACK_MISSING
	} ack_kind_t;

	// Remote transaction type toward the autonomous resources
	typedef enum logic [1:0] {
		TC_QUAD_READ,
		TC_QUAD_LOCK,
		TC_OTHER
	} tcode_t;

	// Acknowledge code of the generated answer
	typedef enum logic {
		RESP_COMPLETE,
		RESP_TYPE_ERROR
	} resp_code_t;

	// Host compare-and-swap sequencer
	typedef enum logic {
		SWAP_IDLE,
		SWAP_WAIT
	} swap_state_t;

endpackage

// ### core/csr_swap_unit.sv
`timescale 1ns/1ps
`include "bus_mgmt_regs.svh"

module csr_swap_unit (
	// Clock and reset
	input  logic        core_clk,
	input  logic        rst,
	input  logic        bus_reset,
	// Remote lock request
	input  logic        bus_go,
	input  logic [1:0]  bus_sel,
	input  logic [31:0] bus_cmp,
	input  logic [31:0] bus_new,
	// Host swap request
	input  logic        host_go,
	input  logic [1:0]  host_sel,
	input  logic [31:0] host_cmp,
	input  logic [31:0] host_new,
	// Results
	output logic [31:0] old_value,
	output logic        bus_done,
	output logic        host_done,
	// Read path for remote quadlet reads
	input  logic [1:0]  rd_sel,
	output logic [31:0] rd_value
);

	logic [31:0] res_reg [4];
	logic        use_bus;
	logic [1:0]  op_sel;
	logic [31:0] op_cmp;
	logic [31:0] op_new;

	// Remote lock wins a tie; the host request simply waits a cycle
	assign use_bus  = bus_go;
	assign op_sel   = use_bus ? bus_sel : host_sel;
	assign op_cmp   = use_bus ? bus_cmp : host_cmp;
	assign op_new   = use_bus ? bus_new : host_new;
	assign rd_value = res_reg[rd_sel];

	// One storage word per resource; only a matching compare writes it
	for (genvar i = 0; i < 4; i++) begin : g_res
		localparam logic [31:0] RELOAD = (i == 0) ? `BM_ID_RESET :
			(i == 1) ? `BANDWIDTH_RESET : `CHANNELS_RESET;
		always_ff @(posedge core_clk) begin
			if (rst || bus_reset) begin
				res_reg[i] <= RELOAD; // R12
			end else if ((bus_go || host_go) && op_sel == 2'(i) && res_reg[i] == op_cmp) begin
				res_reg[i] <= op_new; // R13
			end
		end
	end

	// Old value and completion strobes, one cycle after the request
	always_ff @(posedge core_clk) begin
		if (rst) begin
			old_value <= 32'h00000000;
			bus_done  <= 1'b0;
			host_done <= 1'b0;
		end else begin
			bus_done  <= bus_go;
			host_done <= host_go && !bus_go;
			if (bus_go || host_go) begin
				old_value <= res_reg[op_sel]; // R9
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	res_reload_a: assert property (bus_reset |=> res_reg[1] == `BANDWIDTH_RESET && res_reg[0] == `BM_ID_RESET) // R12
		else $error("resources not reloaded after bus reset");
	no_blind_write_a: assert property ($changed(res_reg[2]) && !$past(bus_reset) |-> // R13
		$past(res_reg[2]) == $past(op_cmp) && $past(op_sel) == 2'h2)
		else $error("resource changed without matching compare");

endmodule

// ### core/bus_mgmt_resources.sv
`timescale 1ns/1ps
`include "bus_mgmt_regs.svh"

// How it works
// [R1] Retry only after busy or data-error acknowledge
// [R2] Physical responses dropped silently past their limit
// [R3] Bits 7:4 limit software response retries
// [R4] Bits 3:0 limit request retries
// [R5] Retry time limit fields read zero, unused
// [R6] Remote side: quadlet read/lock only, else type error
// [R7] Remote locks autonomous; failed lock ack raises event
// [R8] Host writes data, compare, then control
// [R9] Control write starts swap; old value returned
// [R10] Done flag resets one, clears on write
// [R11] Selector picks manager, bandwidth, channels hi/lo
// [R12] Resources reload on hardware or bus reset
// [R13] Resources change only by compare-and-swap
// [R14] ROM header read/write, resets zero, remotely readable
// [R15] Bus identification is constant 31333934h
// [R16] Bus options loaded from EEPROM after reset
// [R17] Max receive resets to 1024 without EEPROM
// [R18] Oversize non-physical block writes get type error
// [R19] Link speed: reset 400, software may only lower
// [R20] Generation counts up on ROM change per reset
// [R21] Software keeps header and options valid while linked
// [R22] ROM port shows last byte in bits 23:16
module bus_mgmt_resources
	import bus_mgmt_pkg::*;
(
	// Clock and reset
	input  logic        core_clk,
	input  logic        rst,
	// Host register port
	input  logic        reg_wr,
	input  logic        reg_rd,
	input  logic [7:0]  reg_addr,
	input  logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic        reg_ack,
	// Link-wide events and controls
	input  logic        bus_reset,
	input  logic        rom_changed,
	input  logic        link_spd_protect,
	// EEPROM loader
	input  logic        eeprom_load,
	input  logic [31:0] eeprom_bus_options,
	// GUID ROM reader
	input  logic        rom_byte_valid,
	input  logic [7:0]  rom_byte_read,
	// Transmit units: 0 request, 1 software response, 2 physical response
	input  logic [2:0]  tx_ack_valid,
	input  ack_kind_t   tx_ack_kind [3],
	output logic [2:0]  tx_retry,
	output logic [2:0]  tx_give_up,
	// Remote requests to resources and bus info block
	input  logic        rq_valid,
	input  tcode_t      rq_tcode,
	input  logic        rq_info,
	input  logic [2:0]  rq_index,
	input  logic [31:0] rq_cmp,
	input  logic [31:0] rq_new,
	output logic        rs_valid,
	output resp_code_t  rs_code,
	output logic [31:0] rs_data,
	// Acknowledge of the generated lock response
	input  logic        lock_ack_valid,
	input  logic        lock_ack_complete,
	output logic        lock_response_fault_event,
	// Received packet admission check
	input  logic        rx_chk_valid,
	input  logic [2:0]  rx_chk_speed,
	input  logic        rx_chk_block_write,
	input  logic [15:0] rx_chk_length,
	input  logic        rx_chk_physical,
	output logic        rx_chk_done,
	output logic        rx_chk_reject
);

	logic [4:0]  phys_retry_reg;
	logic [3:0]  swrsp_retry_reg;
	logic [3:0]  req_retry_reg;
	logic [31:0] swap_data_reg;
	logic [31:0] swap_cmp_reg;
	logic [1:0]  swap_sel_reg;
	logic        swap_done_reg;
	swap_state_t swap_state_reg;
	logic [31:0] rom_header_reg;
	logic [31:0] bus_opt_reg;
	logic        rom_dirty_reg;
	logic [31:0] uid_high_reg;
	logic [31:0] uid_low_reg;
	logic [7:0]  rom_byte_reg;
	logic [31:0] rdata_next;
	logic        wr_swap_ctrl;
	logic        host_go;
	logic        bus_go;
	logic [31:0] old_value;
	logic        bus_done;
	logic        host_done;
	logic [31:0] res_rd_value;
	logic [2:0]  link_spd;
	logic [3:0]  max_rec;
	logic [16:0] max_bytes;
	logic [4:0]  retry_limit [3];
	logic [4:0]  retry_cnt_reg [3];
	logic        retry_reg [3];
	logic        give_up_reg [3];

	assign wr_swap_ctrl = reg_wr && reg_addr == `OFS_SWAP_CONTROL;
	assign link_spd     = bus_opt_reg[`LINK_SPD_HI:`LINK_SPD_LO];
	assign max_rec      = bus_opt_reg[`MAX_REC_HI:`MAX_REC_LO];
	// Block size is 2^(max_rec+1) bytes
	assign max_bytes    = 17'h00001 << ({1'b0, max_rec} + 5'h01);

	// Retry limit register; time limit fields are not stored at all
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phys_retry_reg  <= 5'h00;
			swrsp_retry_reg <= 4'h0;
			req_retry_reg   <= 4'h0;
		end else if (reg_wr && reg_addr == `OFS_RETRY_LIMITS) begin
			phys_retry_reg  <= reg_wdata[`PHYS_RETRY_HI:`PHYS_RETRY_LO]; // R2
			swrsp_retry_reg <= reg_wdata[`SWRSP_RETRY_HI:`SWRSP_RETRY_LO]; // R3
			req_retry_reg   <= reg_wdata[`REQ_RETRY_HI:`REQ_RETRY_LO]; // R4
		end
	end

	assign retry_limit[0] = {1'b0, req_retry_reg}; // R4
	assign retry_limit[1] = {1'b0, swrsp_retry_reg}; // R3
	assign retry_limit[2] = phys_retry_reg; // R2

	// Per-unit retry counters; a packet's count restarts on any final outcome
	for (genvar u = 0; u < 3; u++) begin : g_retry
		always_ff @(posedge core_clk) begin
			if (rst) begin
				retry_cnt_reg[u] <= 5'h00;
				retry_reg[u]     <= 1'b0;
				give_up_reg[u]   <= 1'b0;
			end else begin
				retry_reg[u]   <= 1'b0;
				give_up_reg[u] <= 1'b0;
				if (tx_ack_valid[u]) begin
					if (tx_ack_kind[u] == ACK_BUSY || tx_ack_kind[u] == ACK_DATA_ERROR) begin
						if (retry_cnt_reg[u] < retry_limit[u]) begin
							retry_reg[u]     <= 1'b1; // R1
							retry_cnt_reg[u] <= retry_cnt_reg[u] + 5'h01;
						end else begin
							// Physical give-up raises no event toward software
							give_up_reg[u]   <= 1'b1; // R2
							retry_cnt_reg[u] <= 5'h00;
						end
					end else begin
						retry_cnt_reg[u] <= 5'h00; // R1
					end
				end
			end
		end
		assign tx_retry[u]   = retry_reg[u];
		assign tx_give_up[u] = give_up_reg[u];

		retry_cause_a: assert property (@(posedge core_clk) disable iff (rst) // R1
			retry_reg[u] |-> $past(tx_ack_valid[u]) &&
			($past(tx_ack_kind[u]) == ACK_BUSY || $past(tx_ack_kind[u]) == ACK_DATA_ERROR))
			else $error("retry without busy or data error acknowledge");
		give_up_limit_a: assert property (@(posedge core_clk) disable iff (rst) // R2
			give_up_reg[u] |-> $past(retry_cnt_reg[u]) == $past(retry_limit[u]))
			else $error("give-up before retry count exhausted");
	end

	// Host swap operands; hardware's old value wins over a same-cycle write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			swap_data_reg <= 32'h00000000;
			swap_cmp_reg  <= 32'h00000000;
		end else begin
			if (host_done) begin
				swap_data_reg <= old_value; // R9
			end else if (reg_wr && reg_addr == `OFS_SWAP_DATA) begin
				swap_data_reg <= reg_wdata; // R8
			end
			if (reg_wr && reg_addr == `OFS_SWAP_COMPARE) begin
				swap_cmp_reg <= reg_wdata; // R8
			end
		end
	end

	// Host swap sequencer; a control write restarts it with the new selector
	always_ff @(posedge core_clk) begin
		if (rst) begin
			swap_state_reg <= SWAP_IDLE;
			swap_sel_reg   <= 2'h0;
			swap_done_reg  <= 1'b1; // R10
		end else if (wr_swap_ctrl) begin
			swap_state_reg <= SWAP_WAIT; // R9
			swap_sel_reg   <= reg_wdata[`SWAP_SEL_HI:`SWAP_SEL_LO]; // R11
			swap_done_reg  <= 1'b0; // R10
		end else begin
			case (swap_state_reg)
				SWAP_IDLE: begin
					swap_state_reg <= SWAP_IDLE;
				end
				SWAP_WAIT: begin
					if (host_done) begin
						swap_state_reg <= SWAP_IDLE;
						swap_done_reg  <= 1'b1; // R10
					end
				end
				default: begin
					swap_state_reg <= SWAP_IDLE;
				end
			endcase
		end
	end

	// Hold the request off while its result is landing, so it runs once
	assign host_go = swap_state_reg == SWAP_WAIT && !host_done && !wr_swap_ctrl;
	assign bus_go  = rq_valid && !rq_info && rq_tcode == TC_QUAD_LOCK; // R7

	csr_swap_unit u_swap (
		.core_clk  (core_clk),
		.rst       (rst),
		.bus_reset (bus_reset),
		.bus_go    (bus_go),
		.bus_sel   (rq_index[1:0]),
		.bus_cmp   (rq_cmp),
		.bus_new   (rq_new),
		.host_go   (host_go),
		.host_sel  (swap_sel_reg),
		.host_cmp  (swap_cmp_reg),
		.host_new  (swap_data_reg),
		.old_value (old_value),
		.bus_done  (bus_done),
		.host_done (host_done),
		.rd_sel    (rq_index[1:0]),
		.rd_value  (res_rd_value)
	);

	// Remote answers: reads one cycle after the request, locks one cycle after the swap result
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rs_valid <= 1'b0;
			rs_code  <= RESP_COMPLETE;
			rs_data  <= 32'h00000000;
		end else begin
			rs_valid <= 1'b0;
			if (bus_done) begin
				rs_valid <= 1'b1; // R7
				rs_code  <= RESP_COMPLETE;
				rs_data  <= old_value;
			end else if (rq_valid && !bus_go) begin
				rs_valid <= 1'b1;
				rs_code  <= RESP_TYPE_ERROR; // R6
				rs_data  <= 32'h00000000;
				if (rq_tcode == TC_QUAD_READ && !rq_info) begin
					rs_code <= RESP_COMPLETE;
					rs_data <= res_rd_value; // R11
				end else if (rq_tcode == TC_QUAD_READ && rq_index <= 3'h4) begin
					rs_code <= RESP_COMPLETE;
					case (rq_index)
						3'h0:    rs_data <= rom_header_reg; // R14
						3'h1:    rs_data <= `BUS_ID_VALUE; // R15
						3'h2:    rs_data <= bus_opt_reg; // R16
						3'h3:    rs_data <= uid_high_reg;
						default: rs_data <= uid_low_reg;
					endcase
				end
			end
		end
	end

	// A lock answer acknowledged with anything but complete is reported
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lock_response_fault_event <= 1'b0;
		end else begin
			lock_response_fault_event <= lock_ack_valid && !lock_ack_complete; // R7
		end
	end

	// Header and unique ID words; software keeps them valid while linked
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rom_header_reg <= 32'h00000000; // R14
			uid_high_reg   <= 32'h00000000;
			uid_low_reg    <= 32'h00000000;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_ROM_HEADER) begin
				rom_header_reg <= reg_wdata; // R14
			end
			if (reg_addr == `OFS_UID_HIGH) begin
				uid_high_reg <= reg_wdata;
			end
			if (reg_addr == `OFS_UID_LOW) begin
				uid_low_reg <= reg_wdata;
			end
		end
	end

	// Bus options: EEPROM load beats software; software may only lower the speed
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_opt_reg <= {16'h0000, `MAX_REC_HW_RESET, 9'h000, `LINK_SPD_HW_RESET}; // R17
		end else if (eeprom_load) begin
			bus_opt_reg <= eeprom_bus_options & (`BUS_OPT_WR_MASK | 32'h00000007); // R16
		end else begin
			if (bus_reset && rom_dirty_reg) begin
				bus_opt_reg[`GEN_HI:`GEN_LO] <= bus_opt_reg[`GEN_HI:`GEN_LO] + 2'h1; // R20
			end else if (reg_wr && reg_addr == `OFS_BUS_OPTIONS) begin
				bus_opt_reg[31:3] <= 29'(reg_wdata[31:3] & (`BUS_OPT_WR_MASK >> 3));
				if (!link_spd_protect && reg_wdata[`LINK_SPD_HI:`LINK_SPD_LO] < link_spd) begin
					bus_opt_reg[`LINK_SPD_HI:`LINK_SPD_LO] <= reg_wdata[`LINK_SPD_HI:`LINK_SPD_LO]; // R19
				end
			end
		end
	end

	// ROM change tracker; a change in the reset cycle survives to the next
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rom_dirty_reg <= 1'b0;
		end else if (rom_changed || (reg_wr && reg_addr == `OFS_ROM_HEADER)) begin
			rom_dirty_reg <= 1'b1; // R20
		end else if (bus_reset) begin
			rom_dirty_reg <= 1'b0;
		end
	end

	// Latest GUID ROM byte
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rom_byte_reg <= 8'h00;
		end else if (rom_byte_valid) begin
			rom_byte_reg <= rom_byte_read; // R22
		end
	end

	// Admission check of received packets against speed and size
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_chk_done   <= 1'b0;
			rx_chk_reject <= 1'b0;
		end else begin
			rx_chk_done   <= rx_chk_valid;
			rx_chk_reject <= rx_chk_valid && (rx_chk_speed > link_spd || // R19
				(rx_chk_block_write && !rx_chk_physical && {1'b0, rx_chk_length} > max_bytes)); // R18
		end
	end

	// Read data selection; unmapped and reserved bits read zero
	always_comb begin
		rdata_next = 32'h00000000;
		case (reg_addr)
			`OFS_GUID_ROM_PORT: rdata_next[`ROM_BYTE_HI:`ROM_BYTE_LO] = rom_byte_reg; // R22
			`OFS_RETRY_LIMITS:  rdata_next = {16'h0000, phys_retry_reg, 3'h0, swrsp_retry_reg, req_retry_reg}; // R5
			`OFS_SWAP_DATA:     rdata_next = swap_data_reg;
			`OFS_SWAP_COMPARE:  rdata_next = swap_cmp_reg;
			`OFS_SWAP_CONTROL:  rdata_next = {swap_done_reg, 29'h00000000, swap_sel_reg};
			`OFS_ROM_HEADER:    rdata_next = rom_header_reg;
			`OFS_BUS_ID:        rdata_next = `BUS_ID_VALUE; // R15
			`OFS_BUS_OPTIONS:   rdata_next = bus_opt_reg;
			`OFS_UID_HIGH:      rdata_next = uid_high_reg;
			`OFS_UID_LOW:       rdata_next = uid_low_reg;
			default:            rdata_next = 32'h00000000;
		endcase
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
			reg_ack   <= 1'b0;
		end else begin
			reg_ack   <= reg_rd || reg_wr;
			reg_rdata <= reg_rd ? rdata_next : 32'h00000000;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence host_swap_start;
		reg_wr && reg_addr == `OFS_SWAP_CONTROL;
	endsequence

	sequence quiet_host_port;
		!reg_wr [*4];
	endsequence

	done_clears_a: assert property (host_swap_start |=> !swap_done_reg) // R10
		else $error("done flag not cleared by control write");
	swap_finishes_a: assert property (host_swap_start ##1 quiet_host_port |-> swap_done_reg) // R9
		else $error("host swap did not complete");
	old_value_back_a: assert property (host_done |=> swap_data_reg == $past(old_value)) // R9
		else $error("old value not placed in swap data");
	type_error_a: assert property (rq_valid && rq_tcode == TC_OTHER && !bus_done |=> // R6
		rs_valid && rs_code == RESP_TYPE_ERROR)
		else $error("illegal remote type not refused");
	lock_answer_a: assert property (bus_go |=> ##1 rs_valid && rs_code == RESP_COMPLETE) // R7
		else $error("remote lock not answered");
	lock_fault_a: assert property (lock_ack_valid && !lock_ack_complete |=> lock_response_fault_event) // R7
		else $error("lock fault event missing");
	bus_id_read_a: assert property (reg_rd && reg_addr == `OFS_BUS_ID |=> reg_ack && reg_rdata == `BUS_ID_VALUE) // R15
		else $error("bus identification wrong");
	speed_no_raise_a: assert property (!$past(eeprom_load) && link_spd > $past(link_spd) |-> 1'b0) // R19
		else $error("link speed raised without EEPROM load");
	oversize_reject_a: assert property (rx_chk_valid && rx_chk_block_write && !rx_chk_physical && // R18
		{1'b0, rx_chk_length} > max_bytes |=> rx_chk_reject)
		else $error("oversize block write not rejected");

endmodule

// ### test/remote_node_model.sv
`timescale 1ns/1ps

module remote_node_model
	import bus_mgmt_pkg::*;
(
	// Clock
	input  wire logic        core_clk,
	// Requests toward the resources
	output logic             rq_valid,
	output tcode_t           rq_tcode,
	output logic             rq_info,
	output logic [2:0]       rq_index,
	output logic [31:0]      rq_cmp,
	output logic [31:0]      rq_new,
	// Answers from the device
	input  wire logic        rs_valid,
	input  wire resp_code_t  rs_code,
	input  wire logic [31:0] rs_data,
	// Acknowledge of the device's lock response
	output logic             lock_ack_valid,
	output logic             lock_ack_complete
);
	// Idle lines carry flipped data so a stale sample never looks right
	initial begin
		rq_valid = 1'b0;
		rq_tcode = TC_QUAD_READ;
		rq_info = 1'b0;
		rq_index = 3'h0;
		rq_cmp = 32'h0;
		rq_new = 32'h0;
		lock_ack_valid = 1'b0;
		lock_ack_complete = 1'b0;
	end

	// One request, then wait a bounded time for the answer
	task automatic req(input tcode_t t, input logic inf, input logic [2:0] ix, input logic [31:0] c, n,
		output logic [31:0] code, output logic [31:0] d);
		int i;
		code = 32'hDEAD;
		d = 32'hDEAD;
		@(posedge core_clk);
		#1 rq_valid = 1'b1;
		rq_tcode = t;
		rq_info = inf;
		rq_index = ix;
		rq_cmp = c;
		rq_new = n;
		for (i = 0; i < 3; i++) begin
			@(posedge core_clk);
			#1 rq_valid = 1'b0;
			rq_cmp = ~c;
			rq_new = ~n;
			if (rs_valid === 1'b1) begin
				code = 32'(rs_code);
				d = rs_data;
				i = 3;
			end
		end
	endtask

	// Acknowledge the device's lock response, well or badly
	task automatic ack(input logic ok);
		@(posedge core_clk);
		#1 lock_ack_valid = 1'b1;
		lock_ack_complete = ok;
		@(posedge core_clk);
		#1 lock_ack_valid = 1'b0;
		lock_ack_complete = ~ok;
	endtask
endmodule

// ### test/tb_bus_mgmt_resources.sv
`timescale 1ns/1ps

module tb_bus_mgmt_resources;
	import bus_mgmt_pkg::*;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_ack, bus_reset = 0, rom_changed = 0;
	logic link_spd_protect = 0, eeprom_load = 0, rom_byte_valid = 0, rs_valid, lock_ack_valid;
	logic lock_ack_complete, lock_response_fault_event, rx_chk_valid = 0, rx_chk_block_write = 0;
	logic rx_chk_physical = 0, rx_chk_done, rx_chk_reject, rq_valid, rq_info;
	logic [7:0] reg_addr = 0, rom_byte_read = 0;
	logic [31:0] reg_wdata = 0, eeprom_bus_options = 0, reg_rdata, q, cd, rq_cmp, rq_new, rs_data;
	logic [2:0] tx_ack_valid = 0, tx_retry, tx_give_up, rq_index, rx_chk_speed = 0;
	logic [15:0] rx_chk_length = 0;
	ack_kind_t tx_ack_kind [3] = '{ACK_COMPLETE, ACK_COMPLETE, ACK_COMPLETE};
	tcode_t rq_tcode;
	resp_code_t rs_code;
	int fails = 0, tests_run = 0;
	logic [31:0] rst_val [4] = '{32'h3F, 32'h1333, 32'hFFFFFFFF, 32'hFFFFFFFF};

	bus_mgmt_resources u_bus_mgmt_resources (.*);
	remote_node_model u_remote_node_model (.*);

	// Clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		#1 reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1 reg_wr = 0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge core_clk);
		#1 reg_rd = 1;
		reg_addr = a;
		@(posedge core_clk);
		#1 reg_rd = 0;
		chk({nm, " ack"}, 1, reg_ack);
		chk(nm, e, reg_rdata);
	endtask

	// Host swap; done is low on the read right after the write, high on the next
	task automatic swap(input logic [31:0] nw, cmp, input logic [1:0] s);
		wr(8'h0C, nw);
		wr(8'h10, cmp);
		wr(8'h14, {30'h0, s});
		rd(8'h14, {1'b0, 29'h0, s}, "swap busy");
		rd(8'h14, {1'b1, 29'h0, s}, "swap control");
		chk("swap done", 1, reg_rdata[31]);
	endtask

	task automatic txa(input int u, input ack_kind_t k, input logic r, g);
		@(posedge core_clk);
		#1 tx_ack_valid[u] = 1;
		tx_ack_kind[u] = k;
		@(posedge core_clk);
		#1 tx_ack_valid[u] = 0;
		chk("tx retry", r, tx_retry[u]);
		chk("tx give up", g, tx_give_up[u]);
	endtask

	task automatic rxc(input logic [2:0] sp, input logic [15:0] len, input logic ph, e);
		@(posedge core_clk);
		#1 rx_chk_valid = 1;
		rx_chk_speed = sp;
		rx_chk_block_write = 1;
		rx_chk_length = len;
		rx_chk_physical = ph;
		@(posedge core_clk);
		#1 rx_chk_valid = 0;
		chk("rx done", 1, rx_chk_done);
		chk("rx reject", e, rx_chk_reject);
	endtask

	task automatic t_regs;
		rd(8'h1C, 32'h31333934, "bus id");
		wr(8'h1C, 32'h0);
		rd(8'h1C, 32'h31333934, "bus id");
		rd(8'h14, 32'h80000000, "swap control");
		rd(8'h20, 32'h00009002, "bus options");
		rd(8'h18, 32'h0, "rom header");
		rd(8'h30, 32'h0, "unmapped");
		wr(8'h08, 32'hFFFFFFFF);
		rd(8'h08, 32'h0000F8FF, "retry limits");
		@(posedge core_clk);
		#1 rom_byte_valid = 1;
		rom_byte_read = 8'hA5;
		@(posedge core_clk);
		#1 rom_byte_valid = 0;
		rom_byte_read = 8'h5A;
		rd(8'h04, 32'h00A50000, "rom port");
		$display("regs done");
	endtask

	task automatic t_swap;
		for (int s = 0; s < 4; s++) begin
			swap(32'h0, 32'h12345678, s[1:0]);
			rd(8'h0C, rst_val[s], "swap old");
		end
		swap(32'h1000, 32'h1333, 2'h1);
		rd(8'h0C, 32'h1333, "swap old");
		u_remote_node_model.req(TC_QUAD_READ, 0, 3'h1, 0, 0, cd, q);
		chk("bandwidth", 32'h1000, q);
		$display("swap done");
	endtask

	task automatic t_remote;
		u_remote_node_model.req(TC_QUAD_LOCK, 0, 3'h0, 32'h3F, 32'h5, cd, q);
		chk("lock code", RESP_COMPLETE, cd);
		chk("lock old", 32'h3F, q);
		u_remote_node_model.req(TC_QUAD_READ, 0, 3'h0, 0, 0, cd, q);
		chk("manager id", 32'h5, q);
		u_remote_node_model.req(TC_OTHER, 0, 3'h0, 0, 0, cd, q);
		chk("other code", RESP_TYPE_ERROR, cd);
		u_remote_node_model.req(TC_QUAD_LOCK, 1, 3'h0, 0, 0, cd, q);
		chk("info lock code", RESP_TYPE_ERROR, cd);
		u_remote_node_model.req(TC_QUAD_READ, 1, 3'h1, 0, 0, cd, q);
		chk("info bus id", 32'h31333934, q);
		u_remote_node_model.ack(0);
		chk("lock fault", 1, lock_response_fault_event);
		u_remote_node_model.ack(1);
		chk("lock fault", 0, lock_response_fault_event);
		$display("remote done");
	endtask

	task automatic t_retry;
		wr(8'h08, 32'h00001001);
		txa(0, ACK_BUSY, 1, 0);
		txa(0, ACK_DATA_ERROR, 0, 1);
		txa(0, ACK_MISSING, 0, 0);
		txa(0, ACK_BUSY, 1, 0);
		txa(0, ACK_COMPLETE, 0, 0);
		txa(1, ACK_BUSY, 0, 1);
		txa(2, ACK_BUSY, 1, 0);
		txa(2, ACK_BUSY, 1, 0);
		txa(2, ACK_DATA_ERROR, 0, 1);
		$display("retry done");
	endtask

	task automatic t_bus;
		@(posedge core_clk);
		#1 rom_changed = 1;
		@(posedge core_clk);
		#1 rom_changed = 0;
		bus_reset = 1;
		@(posedge core_clk);
		#1 bus_reset = 0;
		u_remote_node_model.req(TC_QUAD_READ, 0, 3'h0, 0, 0, cd, q);
		chk("manager reload", 32'h3F, q);
		rd(8'h20, 32'h00009042, "generation");
		wr(8'h20, 32'h00009041);
		rd(8'h20, 32'h00009041, "speed lower");
		wr(8'h20, 32'h00009043);
		rd(8'h20, 32'h00009041, "speed raise");
		rxc(3'h2, 16'd16, 0, 1);
		rxc(3'h0, 16'd1025, 0, 1);
		rxc(3'h0, 16'd1024, 0, 0);
		rxc(3'h0, 16'd2000, 1, 0);
		@(posedge core_clk);
		#1 eeprom_load = 1;
		eeprom_bus_options = 32'hFFFFFFFF;
		@(posedge core_clk);
		#1 eeprom_load = 0;
		rd(8'h20, 32'hF8FFF0C7, "eeprom load");
		link_spd_protect = 1;
		wr(8'h20, 32'hF8FFF0C0);
		rd(8'h20, 32'hF8FFF0C7, "speed protect");
		wr(8'h18, 32'h04030201);
		u_remote_node_model.req(TC_QUAD_READ, 1, 3'h0, 0, 0, cd, q);
		chk("info header", 32'h04030201, q);
		$display("bus reset done");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		#1 rst = 0;
		t_regs();
		t_swap();
		t_remote();
		t_retry();
		t_bus();
		end_sim();
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		end_sim();
	end
endmodule
